// >>> pkg/uab_link_if.sv
`timescale 1ns/1ps
interface uab_link_if;
	logic serial_line;
	modport device (input serial_line);
	modport remote (output serial_line);
endinterface

// >>> pkg/uab_pkg.sv
package uab_pkg;
	// ************************************************
	// bus map
	// ************************************************
	localparam int APB_AW = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DIV_LO = 8'h04;
	localparam logic [7:0] OFF_DIV_HI = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFF_RXBUF = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;

	// ************************************************
	// field positions and reset values
	// ************************************************
	localparam int CTRL_W = 5;
	localparam int CTRL_ABD = 0;
	localparam int CTRL_WAKE = 1;
	localparam int CTRL_WIDE = 2;
	localparam int CTRL_HS = 3;
	localparam int CTRL_SYNC = 4;
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_WAKE = 2;
	localparam int STAT_RCF = 0;
	localparam int STAT_HOLD = 1;
	localparam int STAT_RX = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

	// ************************************************
	// timing counts
	// ************************************************
	localparam logic [9:0] PRE_NORM_SLOW = 10'h040;
	localparam logic [9:0] PRE_NORM_MID = 10'h010;
	localparam logic [9:0] PRE_NORM_FAST = 10'h004;
	localparam logic [9:0] PRE_MEAS_00 = 10'h200;
	localparam logic [9:0] PRE_MEAS_01 = 10'h100;
	localparam logic [9:0] PRE_MEAS_10 = 10'h080;
	localparam logic [9:0] PRE_MEAS_11 = 10'h020;
	localparam logic [2:0] EDGE_LAST = 3'h5;
	localparam logic [7:0] CAL_BYTE = 8'h55;
	localparam logic [4:0] FRAME_BITS = 5'h0a;
	localparam logic [4:0] BREAK_FRAME = 5'h0e;
	localparam logic [13:0] BREAK_PATTERN = 14'h2000;

	// ************************************************
	// state types
	// ************************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_BREAK = 5'b00010,
		ST_START = 5'b00100,
		ST_FIRST = 5'b01000,
		ST_COUNT = 5'b10000
	} uab_meas_type;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SHIFT = 2'b10
	} uab_tx_type;
endpackage

// >>> rtl/uab_device.sv
// Functional notes
// - measure only in async mode, wake set or clear
// - start bit with enable set starts measurement
// - generator becomes counter timed by receive line
// - setting enable clears counter, awaits start
// - remote sends 55h calibration byte
// - counting begins at first rising edge
// - fifth rise leaves divisor, clears enable
// - counter clock is one eighth rate, one sixteenth with hs alone
// - both bytes form 16-bit counter
// - main receive machine held idle meanwhile
// - fifth rise sets receive complete flag
// - software reads buffer, discards, clears flag
// - with wake set, measure byte after break
// - software keeps rate within measurable range
// - normal rate oscillator over 64/16/4 times (n+1)
// - divisor write with enable clear restarts rate timer
// - receive level by three-sample majority
`timescale 1ns/1ps
module uab_device
	import uab_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic baud_tick,
	output logic rx_hold_idle,
	uab_link_if.device link
);
	logic rx_level, rx_prev_r, rise, fall;
	logic done_acc, wr, rd;
	logic pready_r, pready_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	uab_meas_type state_r, state_nxt;
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [15:0] div_r, div_nxt;
	logic [9:0] pre_r, pre_nxt;
	logic [15:0] brg_r, brg_nxt;
	logic [2:0] edge_r, edge_nxt;
	logic [IRQ_W-1:0] stat_r, stat_nxt;
	logic [IRQ_W-1:0] mask_r, mask_nxt;
	logic rcf_r, rcf_nxt;
	logic tick_r, tick_nxt;
	logic hold_r, hold_nxt;
	logic irq_r, irq_nxt;
	// ************************************************
	// receive line conditioning
	// ************************************************
	uab_rx_filter #(.SAMPLES(3)) uab_rx_filter_inst (
		.pclk(pclk),
		.presetn(presetn),
		.pin(link.serial_line),
		.level(rx_level)
	);
	assign rise = rx_level & ~rx_prev_r;
	assign fall = ~rx_level & rx_prev_r;
	assign done_acc = psel & penable & pready_r;
	assign wr = done_acc & pwrite;
	assign rd = done_acc & ~pwrite;
	// ************************************************
	// apb slave
	// ************************************************
	always_comb begin
		pready_nxt = psel & penable & ~pready_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		if (psel && penable && !pready_r) begin
			prdata_nxt = 32'h0000_0000;
			case (paddr)
				OFF_CTRL: prdata_nxt = {27'h0, ctrl_r};
				OFF_DIV_LO: prdata_nxt = {24'h0, div_r[7:0]};
				OFF_DIV_HI: prdata_nxt = {24'h0, div_r[15:8]};
				OFF_IRQ_STAT: prdata_nxt = {29'h0, stat_r};
				OFF_IRQ_MASK: prdata_nxt = {29'h0, mask_r};
				OFF_RXBUF: prdata_nxt = 32'h0000_0000;
				OFF_STATUS: prdata_nxt = {29'h0, rx_level, hold_r, rcf_r};
				default: pslverr_nxt = 1'b1;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end
	// ************************************************
	// rate generator and measurement sequencer
	// ************************************************
	always_comb begin
		logic [9:0] pre_lim;
		logic [15:0] div_n;
		logic pre_tick;
		logic [IRQ_W-1:0] set_v;
		logic [IRQ_W-1:0] clr_v;
		pre_lim = PRE_NORM_MID;
		div_n = 16'h0000;
		pre_tick = 1'b0;
		set_v = '0;
		clr_v = '0;
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		div_nxt = div_r;
		brg_nxt = brg_r;
		edge_nxt = edge_r;
		mask_nxt = mask_r;
		rcf_nxt = rcf_r;
		if (state_r == ST_COUNT) begin
			case ({ctrl_r[CTRL_WIDE], ctrl_r[CTRL_HS]})
				2'b00: pre_lim = PRE_MEAS_00;
				2'b01: pre_lim = PRE_MEAS_01;
				2'b10: pre_lim = PRE_MEAS_10;
				default: pre_lim = PRE_MEAS_11;
			endcase
		end else if (ctrl_r[CTRL_SYNC]) begin
			pre_lim = PRE_NORM_FAST;
		end else begin
			case ({ctrl_r[CTRL_WIDE], ctrl_r[CTRL_HS]})
				2'b00: pre_lim = PRE_NORM_SLOW;
				2'b11: pre_lim = PRE_NORM_FAST;
				default: pre_lim = PRE_NORM_MID;
			endcase
		end
		div_n = ctrl_r[CTRL_WIDE] ? div_r : {8'h00, div_r[7:0]};
		pre_tick = (pre_r == pre_lim - 10'h001);
		pre_nxt = pre_tick ? 10'h000 : pre_r + 10'h001;
		tick_nxt = (state_r == ST_IDLE) && pre_tick && (brg_r >= div_n);
		if (state_r == ST_IDLE && pre_tick) begin
			brg_nxt = tick_nxt ? 16'h0000 : brg_r + 16'h0001;
		end
		if (wr) begin
			case (paddr)
				OFF_CTRL: begin
					ctrl_nxt[CTRL_W-1:1] = pwdata[CTRL_W-1:1];
					if (!pwdata[CTRL_ABD]) begin
						ctrl_nxt[CTRL_ABD] = 1'b0;
						state_nxt = ST_IDLE;
					end else if (!ctrl_r[CTRL_ABD] && !pwdata[CTRL_SYNC]) begin
						ctrl_nxt[CTRL_ABD] = 1'b1;
						div_nxt = 16'h0000;
						brg_nxt = 16'h0000;
						pre_nxt = 10'h000;
						state_nxt = pwdata[CTRL_WAKE] ? ST_BREAK : ST_START;
					end
				end
				OFF_DIV_LO, OFF_DIV_HI: begin
					if (!ctrl_r[CTRL_ABD]) begin
						if (paddr == OFF_DIV_HI) begin
							div_nxt[15:8] = pwdata[7:0];
						end else begin
							div_nxt[7:0] = pwdata[7:0];
						end
						pre_nxt = 10'h000;
						brg_nxt = 16'h0000;
					end
				end
				OFF_IRQ_STAT: clr_v = pwdata[IRQ_W-1:0];
				OFF_IRQ_MASK: mask_nxt = pwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		if (rd && paddr == OFF_RXBUF) begin
			rcf_nxt = 1'b0;
		end
		// break end releases the wake enable
		if (ctrl_r[CTRL_WAKE] && rise) begin
			ctrl_nxt[CTRL_WAKE] = 1'b0;
			set_v[IRQ_WAKE] = 1'b1;
		end
		if (ctrl_nxt[CTRL_ABD]) begin
			case (state_r)
				ST_IDLE: ;
				ST_BREAK: begin
					if (!ctrl_r[CTRL_WAKE]) begin
						state_nxt = ST_START;
					end
				end
				ST_START: begin
					if (fall && !ctrl_r[CTRL_WAKE]) begin
						state_nxt = ST_FIRST;
					end
				end
				ST_FIRST: begin
					if (rise) begin
						state_nxt = ST_COUNT;
						pre_nxt = 10'h000;
						edge_nxt = 3'h1;
					end
				end
				ST_COUNT: begin
					if (pre_tick) begin
						div_nxt = div_r + 16'h0001;
						if (div_r == 16'hffff) begin
							set_v[IRQ_OVF] = 1'b1;
						end
					end
					if (rise) begin
						edge_nxt = edge_r + 3'h1;
						if (edge_r == EDGE_LAST - 3'h1) begin
							state_nxt = ST_IDLE;
							ctrl_nxt[CTRL_ABD] = 1'b0;
							rcf_nxt = 1'b1;
							set_v[IRQ_DONE] = 1'b1;
							pre_nxt = 10'h000;
							brg_nxt = 16'h0000;
						end
					end
				end
				default: state_nxt = ST_IDLE;
			endcase
		end
		stat_nxt = (stat_r & ~clr_v) | set_v;
		irq_nxt = |(stat_nxt & mask_nxt);
		hold_nxt = (state_nxt != ST_IDLE);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			ctrl_r <= CTRL_RST;
			div_r <= DIV_RST;
			pre_r <= 10'h000;
			brg_r <= 16'h0000;
			edge_r <= 3'h0;
			stat_r <= '0;
			mask_r <= MASK_RST;
			rcf_r <= 1'b0;
			tick_r <= 1'b0;
			hold_r <= 1'b0;
			irq_r <= 1'b0;
			rx_prev_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			div_r <= div_nxt;
			pre_r <= pre_nxt;
			brg_r <= brg_nxt;
			edge_r <= edge_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			rcf_r <= rcf_nxt;
			tick_r <= tick_nxt;
			hold_r <= hold_nxt;
			irq_r <= irq_nxt;
			rx_prev_r <= rx_level;
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign baud_tick = tick_r;
	assign rx_hold_idle = hold_r;
endmodule

// >>> rtl/uab_remote_tx.sv
`timescale 1ns/1ps
module uab_remote_tx
	import uab_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic send_req,
	input wire logic [7:0] send_data,
	input wire logic cal_req,
	input wire logic break_req,
	input wire logic [15:0] bit_cycles,
	output logic busy,
	uab_link_if.remote link
);
	uab_tx_type state_r;
	uab_tx_type state_nxt;
	logic [13:0] sreg_r;
	logic [13:0] sreg_nxt;
	logic [4:0] bits_r;
	logic [4:0] bits_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic line_r;
	logic line_nxt;
	logic busy_r;
	logic busy_nxt;

	// ************************************************
	// frame shifter
	// ************************************************
	always_comb begin
		state_nxt = state_r;
		sreg_nxt = sreg_r;
		bits_nxt = bits_r;
		cnt_nxt = cnt_r;
		line_nxt = line_r;
		busy_nxt = busy_r;
		case (state_r)
			TX_IDLE: begin
				if (break_req || cal_req || send_req) begin
					if (break_req) begin
						sreg_nxt = BREAK_PATTERN;
						bits_nxt = BREAK_FRAME;
					end else if (cal_req) begin
						sreg_nxt = {4'hf, 1'b1, CAL_BYTE, 1'b0};
						bits_nxt = FRAME_BITS;
					end else begin
						sreg_nxt = {4'hf, 1'b1, send_data, 1'b0};
						bits_nxt = FRAME_BITS;
					end
					line_nxt = 1'b0;
					cnt_nxt = 16'h0000;
					busy_nxt = 1'b1;
					state_nxt = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				cnt_nxt = cnt_r + 16'h0001;
				if (cnt_r + 16'h0001 >= bit_cycles) begin
					cnt_nxt = 16'h0000;
					bits_nxt = bits_r - 5'h01;
					sreg_nxt = {1'b1, sreg_r[13:1]};
					line_nxt = sreg_r[1];
					if (bits_r == 5'h01) begin
						line_nxt = 1'b1;
						busy_nxt = 1'b0;
						state_nxt = TX_IDLE;
					end
				end
			end
			default: begin
				state_nxt = TX_IDLE;
				line_nxt = 1'b1;
				busy_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= TX_IDLE;
			sreg_r <= '1;
			bits_r <= 5'h00;
			cnt_r <= 16'h0000;
			line_r <= 1'b1;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sreg_r <= sreg_nxt;
			bits_r <= bits_nxt;
			cnt_r <= cnt_nxt;
			line_r <= line_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign link.serial_line = line_r;
	assign busy = busy_r;
endmodule

// >>> rtl/uab_rx_filter.sv
`timescale 1ns/1ps
module uab_rx_filter
	import uab_pkg::*;
#(
	parameter int SAMPLES = 3
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output logic level
);
	logic sync1_r;
	logic sync2_r;
	logic [SAMPLES-1:0] hist_r;
	logic [SAMPLES-1:0] hist_nxt;
	logic level_r;
	logic level_nxt;

	if (SAMPLES < 3 || (SAMPLES % 2) == 0) begin : g_chk
		$error("uab_rx_filter: SAMPLES must be odd and at least 3");
	end

	// ************************************************
	// sample history
	// ************************************************
	assign hist_nxt[0] = sync2_r;
	for (genvar i = 1; i < SAMPLES; i++) begin : g_hist
		assign hist_nxt[i] = hist_r[i-1];
	end

	// majority vote
	always_comb begin
		int ones;
		ones = 0;
		for (int i = 0; i < SAMPLES; i++) begin
			ones = ones + int'(hist_r[i]);
		end
		level_nxt = (ones > SAMPLES / 2);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			hist_r <= '1;
			level_r <= 1'b1;
		end else begin
			sync1_r <= pin;
			sync2_r <= sync1_r;
			hist_r <= hist_nxt;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import uab_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, baud_tick, rx_hold_idle;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic cal_req, break_req, busy, last_err;
	logic [15:0] bit_cycles;
	int num_errors, samples_checked;
	uab_link_if link_if_inst();
	uab_device uab_device_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .baud_tick(baud_tick), .rx_hold_idle(rx_hold_idle),
		.link(link_if_inst));
	uab_remote_tx uab_remote_tx_inst (.pclk(pclk), .presetn(presetn), .send_req(1'b0),
		.send_data(CAL_BYTE), .cal_req(cal_req), .break_req(break_req), .bit_cycles(bit_cycles),
		.busy(busy), .link(link_if_inst));
	uab_link_checker uab_link_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
		.baud_tick(baud_tick), .rx_hold_idle(rx_hold_idle), .serial_line(link_if_inst.serial_line));
	// ****
	// shared tasks
	// ****
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		check("apb_wait", n, 2);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic req(input logic brk, input logic [15:0] bc);
		@(posedge pclk);
		bit_cycles <= bc;
		cal_req <= !brk;
		break_req <= brk;
		@(posedge pclk);
		cal_req <= 1'b0;
		break_req <= 1'b0;
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin @(posedge pclk); n++; end while (busy !== 1'b0 && n < 20000);
		check("tx_idle", {31'h0, busy}, 32'h0);
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic rate(input logic [4:0] ctrl, input int k);
		logic [31:0] d;
		int n;
		apb(1'b1, OFF_CTRL, {27'h0, ctrl}, d);
		apb(1'b1, OFF_DIV_HI, 32'h0, d);
		apb(1'b1, OFF_DIV_LO, 32'h3, d);
		for (int i = 0; i < 2; i++) begin
			n = 0;
			do begin @(posedge pclk); #1; n++; end while (baud_tick !== 1'b1 && n < 1000);
		end
		check("period", n, k * 4);
	endtask
	task automatic measure(input logic [4:0] ctrl, input logic [15:0] bc);
		logic [31:0] d, hi, ex;
		int p;
		case ({ctrl[CTRL_WIDE], ctrl[CTRL_HS]})
			2'b00: p = 512;
			2'b01: p = 256;
			2'b10: p = 128;
			default: p = 32;
		endcase
		ex = 8 * bc / p;
		apb(1'b1, OFF_DIV_LO, 32'h12, d);
		apb(1'b1, OFF_IRQ_MASK, 32'h0, d);
		apb(1'b1, OFF_CTRL, {27'h0, ctrl}, d);
		apb(1'b0, OFF_CTRL, 32'h0, d);
		check("enable_set", d[CTRL_ABD], 1'b1);
		apb(1'b0, OFF_DIV_LO, 32'h0, d);
		check("div_cleared", d, 32'h0);
		if (ctrl[CTRL_WAKE]) begin
			req(1'b1, bc);
			wait_idle;
		end
		req(1'b0, bc);
		repeat (3 * bc) @(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0, d);
		check("hold_status", d[STAT_HOLD], 1'b1);
		check("hold_pin", rx_hold_idle, 1'b1);
		wait_idle;
		apb(1'b0, OFF_CTRL, 32'h0, d);
		for (int n = 0; n < 50 && d[CTRL_ABD] !== 1'b0; n++) apb(1'b0, OFF_CTRL, 32'h0, d);
		check("enable_clr", d[CTRL_ABD], 1'b0);
		check("wake_clr", d[CTRL_WAKE], 1'b0);
		apb(1'b0, OFF_DIV_HI, 32'h0, hi);
		apb(1'b0, OFF_DIV_LO, 32'h0, d);
		d = {hi[23:0], d[7:0]};
		check("divisor", {31'h0, d + 1 >= ex && d <= ex + 1}, 32'h1);
		check("div_hi", hi, ex >> 8);
		apb(1'b0, OFF_STATUS, 32'h0, d);
		check("rcf", d[STAT_RCF], 1'b1);
		apb(1'b0, OFF_IRQ_STAT, 32'h0, d);
		check("done", d[IRQ_DONE], 1'b1);
		check("wake_evt", d[IRQ_WAKE], ctrl[CTRL_WAKE]);
		check("irq_masked", irq, 1'b0);
		apb(1'b1, OFF_IRQ_MASK, 32'h1, d);
		repeat (2) @(posedge pclk);
		#1 check("irq_on", irq, 1'b1);
		apb(1'b0, OFF_RXBUF, 32'h0, d);
		check("rxbuf", d, 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0, d);
		check("rcf_clr", d[STAT_RCF], 1'b0);
		apb(1'b1, OFF_IRQ_STAT, 32'h1, d);
		repeat (2) @(posedge pclk);
		#1 check("irq_off", irq, 1'b0);
		check("hold_end", rx_hold_idle, 1'b0);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		num_errors++;
		report_and_stop;
	end
	initial begin
		logic [31:0] d;
		logic [7:0] offs [5] = '{OFF_CTRL, OFF_DIV_LO, OFF_DIV_HI, OFF_IRQ_STAT, OFF_IRQ_MASK};
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; cal_req = 1'b0; break_req = 1'b0; bit_cycles = 16'h0010;
		num_errors = 0; samples_checked = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (offs[i]) begin
			apb(1'b0, offs[i], 32'h0, d);
			check("reset_value", d, 32'h0);
		end
		apb(1'b0, 8'hfc, 32'h0, d);
		check("unmapped", {31'h0, last_err}, 32'h1);
		apb(1'b1, OFF_CTRL, 32'h11, d);
		apb(1'b0, OFF_CTRL, 32'h0, d);
		check("sync_refused", d[CTRL_ABD], 1'b0);
		rate(5'h00, 64);
		rate(5'h08, 16);
		rate(5'h04, 16);
		rate(5'h0c, 4);
		rate(5'h10, 4);
		measure(5'h01, 16'd1024);
		measure(5'h09, 16'd512);
		measure(5'h05, 16'd256);
		measure(5'h0d, 16'd1040);
		measure(5'h07, 16'd256);
		report_and_stop;
	end
endmodule

// >>> testbench/uab_link_checker.sv
`timescale 1ns/1ps
module uab_link_checker
	import uab_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic baud_tick,
	input wire logic rx_hold_idle,
	input wire logic serial_line
);
	// ****
	// bus and rate checks
	// ****
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic div_wr;
	assign div_wr = psel && penable && pready && pwrite && (paddr == OFF_DIV_LO || paddr == OFF_DIV_HI);
	sequence s_access; psel && penable && !pready; endsequence
	sequence s_quiet; !baud_tick [*3]; endsequence
	property p_ready_next; s_access |=> pready; endproperty
	a_ready_next: assert property (p_ready_next) else $error("pready late");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
	property p_ready_cause; pready |-> psel && penable; endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
	property p_tick_gap; baud_tick |=> s_quiet; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
	property p_hold_no_tick; rx_hold_idle && $past(rx_hold_idle) |-> !baud_tick; endproperty
	a_hold_no_tick: assert property (p_hold_no_tick) else $error("tick while measuring");
	property p_done_line; $fell(rx_hold_idle) |-> serial_line; endproperty
	a_done_line: assert property (p_done_line) else $error("end not on high line");
	property p_div_restart; div_wr |=> ##1 !baud_tick [*2]; endproperty
	a_div_restart: assert property (p_div_restart) else $error("no restart on write");
endmodule
